/* xb_cfg.svh */
// constants for the banked sram and expansion decoder and its host controller
`ifndef XB_CFG_SVH
`define XB_CFG_SVH
// host memory map
`define SRAM_LO     16'h2200
`define SRAM_HI     16'ha1ff
`define EXP_LO      16'ha200
`define EXP_HI      16'hfeff
`define REG_LO      16'hff00
`define BANK_REG    16'hff01
`define BANK_RST    4'h0
`define UPPER_ZERO  4'h0
// host controller avalon map, byte addresses
`define A_XADDR     5'h00
`define A_WDATA     5'h04
`define A_CTRL      5'h08
`define A_STATUS    5'h0c
`define A_RDATA     5'h10
// control and status bit positions
`define CTL_EN      0
`define CTL_WS_LO   2
`define CTL_WS_HI   3
`define CTL_GO_WR   4
`define CTL_GO_RD   5
`define ST_BUSY     0
`define ST_DONE     1
// host bus cycle timing in clocks
`define ALE_CYC     4'h2
`define STB_CYC     4'h4
`define WAIT_CYC    4'h2
`endif

/* xb_pkg.sv */
// types used by the host end of the host bus
`default_nettype none
package xb_pkg;
  // host bus cycle phases, one-hot
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_ALE  = 5'h02,
    H_HOLD = 5'h04,
    H_STB  = 5'h08,
    H_END  = 5'h10
  } host_state_t;
endpackage
`default_nettype wire

/* xbus_if.sv */
// multiplexed host bus between controller and decoder
`default_nettype none
interface xbus_if;
  logic [7:0] ad_h2d;   // low address then write data from host
  logic       ad_h_oe;  // host drives ad lines
  logic [7:0] ad_d2h;   // read data from decoder
  logic       ad_d_oe;  // decoder drives ad lines
  logic [7:0] addr_hi;  // upper address
  logic       ale;      // address latch strobe, high
  logic       rd_n;     // read strobe
  logic       wr_n;     // write strobe
  modport host (output ad_h2d, ad_h_oe, addr_hi, ale, rd_n, wr_n,
                input  ad_d2h, ad_d_oe);
  modport dev  (input  ad_h2d, ad_h_oe, addr_hi, ale, rd_n, wr_n,
                output ad_d2h, ad_d_oe);
endinterface // xbus_if
`default_nettype wire

/* exp_host.sv */
// host end: avalon-mm command registers driving the multiplexed bus
//
// Implementation choice: the Avalon-MM register port.
`include "xb_cfg.svh"
`default_nettype none
module exp_host (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // host bus
  xbus_if.host             bus
);
  xb_pkg::host_state_t state_r;
  logic [15:0] xaddr_r;
  logic [7:0]  wdata_r;
  logic [7:0]  rdata_r;
  logic        en_r;
  logic [1:0]  ws_r;
  logic        dir_rd_r;
  logic        done_r;
  logic [3:0]  cnt_r;
  logic        req;
  logic        acc;
  logic        go;
  logic [31:0] rd_mux;

  // ****************************************
  // avalon slave
  // ****************************************
  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~avs_waitrequest_out;
  // start only when enabled and idle; otherwise the order is dropped
  assign go  = acc & avs_write_in & (avs_address_in == `A_CTRL) & en_r
             & (state_r == xb_pkg::H_IDLE)
             & (avs_writedata_in[`CTL_GO_WR] | avs_writedata_in[`CTL_GO_RD]);

  // one wait cycle on every access, then accept
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_in)
      `A_XADDR:  rd_mux = {16'h0, xaddr_r};
      `A_WDATA:  rd_mux = {24'h0, wdata_r};
      `A_CTRL:   rd_mux = {28'h0, ws_r, 1'b0, en_r};
      `A_STATUS: rd_mux = {30'h0, done_r, (state_r != xb_pkg::H_IDLE)};
      `A_RDATA:  rd_mux = {24'h0, rdata_r};
      default:   rd_mux = 32'h0;
    endcase
  end

  // read data loaded during the wait cycle so it stands at acceptance
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in & avs_waitrequest_out) begin
      avs_readdata_out <= rd_mux;
    end
  end

  // software registers; address kept so a read may be followed by a write back
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      xaddr_r <= 16'h0;
      wdata_r <= 8'h0;
      en_r    <= 1'b0;
      ws_r    <= 2'h0;
    end else if (acc & avs_write_in) begin
      if (avs_address_in == `A_XADDR) xaddr_r <= avs_writedata_in[15:0];
      if (avs_address_in == `A_WDATA) wdata_r <= avs_writedata_in[7:0];
      if (avs_address_in == `A_CTRL) begin
        en_r <= avs_writedata_in[`CTL_EN];
        ws_r <= avs_writedata_in[`CTL_WS_HI:`CTL_WS_LO];
      end
    end
  end

  // done is set at cycle end, cleared by an accepted start
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      done_r <= 1'b0;
    end else if (state_r == xb_pkg::H_END) begin
      done_r <= 1'b1;
    end else if (go) begin
      done_r <= 1'b0;
    end
  end

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r     <= xb_pkg::H_IDLE;
      cnt_r       <= 4'h0;
      dir_rd_r    <= 1'b0;
      rdata_r     <= 8'h0;
      bus.ale     <= 1'b0;
      bus.rd_n    <= 1'b1;
      bus.wr_n    <= 1'b1;
      bus.ad_h2d  <= 8'h0;
      bus.ad_h_oe <= 1'b0;
      bus.addr_hi <= 8'h0;
    end else begin
      case (state_r)
        xb_pkg::H_IDLE: if (go) begin
          dir_rd_r    <= avs_writedata_in[`CTL_GO_RD];
          bus.ale     <= 1'b1;
          bus.ad_h2d  <= xaddr_r[7:0];
          bus.ad_h_oe <= 1'b1;
          bus.addr_hi <= xaddr_r[15:8];
          cnt_r       <= `ALE_CYC - 4'h1;
          state_r     <= xb_pkg::H_ALE;
        end
        xb_pkg::H_ALE: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            bus.ale <= 1'b0;
            state_r <= xb_pkg::H_HOLD;
          end
        end
        // address held one clock after the latch strobe falls
        xb_pkg::H_HOLD: begin
          bus.rd_n    <= ~dir_rd_r;
          bus.wr_n    <= dir_rd_r;
          bus.ad_h2d  <= wdata_r;
          bus.ad_h_oe <= ~dir_rd_r;
          cnt_r       <= `STB_CYC - 4'h1 + ({2'h0, ws_r} * `WAIT_CYC);
          state_r     <= xb_pkg::H_STB;
        end
        xb_pkg::H_STB: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            // lines nobody drives read as zero rather than a stale byte
            if (dir_rd_r) rdata_r <= bus.ad_d_oe ? bus.ad_d2h : 8'h00;
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            state_r  <= xb_pkg::H_END;
          end
        end
        xb_pkg::H_END: begin
          bus.ad_h_oe <= 1'b0;
          state_r     <= xb_pkg::H_IDLE;
        end
        default: state_r <= xb_pkg::H_IDLE;
      endcase
    end
  end
endmodule // exp_host
`default_nettype wire

/* exp_decoder.sv */
// device end: address latch, bank register, sram and expansion decode
`include "xb_cfg.svh"
`default_nettype none
module exp_decoder #(
  parameter int BANK_W = 4,
  parameter int OFS_W  = 15
) (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  // host bus
  xbus_if.dev                          bus,
  // banked sram
  output logic [BANK_W+OFS_W-1:0]      sram_addr_out,
  output logic                         sram_ce_n_out,
  output logic                         sram_oe_n_out,
  output logic                         sram_we_n_out,
  output logic [7:0]                   sram_data_out,
  output logic                         sram_data_oe_out,
  input  wire logic [7:0]              sram_data_in,
  // expansion bus
  output logic                         exp_en_n_out,
  output logic                         exp_rd_n_out,
  output logic                         exp_wr_n_out,
  output logic [15:0]                  exp_addr_out,
  output logic [7:0]                   exp_data_out,
  output logic                         exp_data_oe_out,
  input  wire logic [7:0]              exp_data_in,
  // buffered reset, active low
  output logic                         buffered_reset_out_n
);
  logic [7:0]        addr_lo_r;
  logic [BANK_W-1:0] bank_number_field;
  logic              wr_q_r;
  logic [15:0]       full_addr;
  logic [15:0]       ofs_full;
  logic              in_sram;
  logic              in_exp;
  logic              in_reg;
  logic              active;
  logic              rd_act;
  logic              wr_act;
  logic              bank_wr;
  logic [7:0]        rd_mux;
  logic [7:0]        sram_bank_selector;

  // ****************************************
  // address latch and decode
  // ****************************************

  // low byte captured while the latch strobe is high; holds once it falls
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      addr_lo_r <= 8'h0;
    end else if (bus.ale & bus.ad_h_oe) begin
      addr_lo_r <= bus.ad_h2d;
    end
  end

  assign full_addr = {bus.addr_hi, addr_lo_r};
  // window offset; the window is 32KB so it fits the low offset bits
  assign ofs_full  = full_addr - `SRAM_LO;

  // three disjoint windows; the register page is kept out of both
  assign in_sram = (full_addr >= `SRAM_LO) & (full_addr <= `SRAM_HI);
  assign in_exp  = (full_addr >= `EXP_LO) & (full_addr <= `EXP_HI);
  assign in_reg  = (full_addr >= `REG_LO);

  // strobes count only once the address phase is over
  assign rd_act = ~bus.rd_n & ~bus.ale;
  assign wr_act = ~bus.wr_n & ~bus.ale;
  assign active = rd_act | wr_act;

  // ****************************************
  // bank register
  // ****************************************

  // previous write strobe, to act once per write cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_q_r <= 1'b1;
    end else begin
      wr_q_r <= bus.wr_n;
    end
  end

  // first clock of the write strobe; data is already on the lines then
  assign bank_wr = wr_act & wr_q_r & bus.ad_h_oe & (full_addr == `BANK_REG);

  // only the low bits are stored; the upper bits have no storage at all
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bank_number_field <= `BANK_RST;
    end else if (bank_wr) begin
      bank_number_field <= bus.ad_h2d[BANK_W-1:0];
    end
  end

  // readback image, upper nibble always zero
  assign sram_bank_selector = {`UPPER_ZERO, bank_number_field};

  // ****************************************
  // banked sram
  // ****************************************

  // one bank at a time: the bank number forms the top sram address bits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sram_addr_out    <= '0;
      sram_ce_n_out    <= 1'b1;
      sram_oe_n_out    <= 1'b1;
      sram_we_n_out    <= 1'b1;
      sram_data_out    <= 8'h0;
      sram_data_oe_out <= 1'b0;
    end else begin
      sram_addr_out    <= {bank_number_field, ofs_full[OFS_W-1:0]};
      sram_ce_n_out    <= ~(active & in_sram);
      sram_oe_n_out    <= ~(rd_act & in_sram);
      sram_we_n_out    <= ~(wr_act & in_sram);
      sram_data_out    <= bus.ad_h2d;
      sram_data_oe_out <= wr_act & in_sram;
    end
  end

  // ****************************************
  // expansion bus
  // ****************************************

  // strobes are gated by the window as well, so they never move alone
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      exp_en_n_out    <= 1'b1;
      exp_rd_n_out    <= 1'b1;
      exp_wr_n_out    <= 1'b1;
    end else begin
      exp_en_n_out    <= ~(active & in_exp);
      exp_rd_n_out    <= ~(rd_act & in_exp);
      exp_wr_n_out    <= ~(wr_act & in_exp);
    end
  end

  // address and write data follow the host bus every clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      exp_addr_out    <= 16'h0;
      exp_data_out    <= 8'h0;
      exp_data_oe_out <= 1'b0;
    end else begin
      exp_addr_out    <= full_addr;
      exp_data_out    <= bus.ad_h2d;
      exp_data_oe_out <= wr_act & in_exp;
    end
  end

  // ****************************************
  // read return to the host
  // ****************************************

  // unused register page locations read as zero
  always_comb begin
    rd_mux = 8'h0;
    if (in_sram) begin
      rd_mux = sram_data_in;
    end else if (in_exp) begin
      rd_mux = exp_data_in;
    end else if (full_addr == `BANK_REG) begin
      rd_mux = sram_bank_selector;
    end
  end

  // one clock from strobe to data, as the pin data passes a register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus.ad_d2h  <= 8'h0;
      bus.ad_d_oe <= 1'b0;
    end else begin
      bus.ad_d2h  <= rd_mux;
      bus.ad_d_oe <= rd_act & (in_sram | in_exp | in_reg);
    end
  end

  // ****************************************
  // buffered reset
  // ****************************************

  // one clock behind the system reset; nothing outside may pull it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      buffered_reset_out_n <= 1'b0;
    end else begin
      buffered_reset_out_n <= 1'b1;
    end
  end
endmodule // exp_decoder
`default_nettype wire

/* xb_props.sv */
// assertions on the host bus and the decoder's expansion and sram outputs
`default_nettype none
module xb_props (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // host bus
  input wire logic [7:0]  ad_h2d,
  input wire logic [7:0]  ad_d2h,
  input wire logic        ad_d_oe,
  input wire logic [7:0]  addr_hi,
  input wire logic        rd_n,
  input wire logic        wr_n,
  // decoder outputs and expansion input
  input wire logic        sram_ce_n_out,
  input wire logic        exp_en_n_out,
  input wire logic        exp_rd_n_out,
  input wire logic        exp_wr_n_out,
  input wire logic [15:0] exp_addr_out,
  input wire logic [7:0]  exp_data_out,
  input wire logic [7:0]  exp_data_in,
  input wire logic        buffered_reset_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_exp;
  logic in_sram;
  logic busy;
  // upper byte alone fixes both windows, the low byte never crosses an edge
  assign in_exp = addr_hi >= 8'ha2 && addr_hi <= 8'hfe;
  assign in_sram = addr_hi >= 8'h22 && addr_hi <= 8'ha1;
  assign busy = !(rd_n && wr_n);
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ****************************************
  // expansion decode
  // ****************************************
  chk_en_in_range: assert property (
    !exp_en_n_out |-> exp_addr_out >= 16'ha200 && exp_addr_out <= 16'hfeff)
    else $error("expansion enable low outside its window");
  chk_rd_strobe: assert property (
    (!rd_n && in_exp) |=> !exp_en_n_out && !exp_rd_n_out && exp_wr_n_out)
    else $error("expansion read strobe missing");
  chk_wr_strobe: assert property (
    (!wr_n && in_exp) |=> !exp_en_n_out && !exp_wr_n_out && exp_data_out == $past(ad_h2d))
    else $error("expansion write strobe or data wrong");
  chk_addr_high: assert property (
    !exp_en_n_out |-> exp_addr_out[15:8] == $past(addr_hi))
    else $error("expansion upper address differs from host");
  chk_rd_data: assert property (
    ($fell(rd_n) && in_exp) |-> ##2 (ad_d_oe && ad_d2h == exp_data_in))
    else $error("expansion read byte not returned");
  chk_en_idle: assert property (
    (rd_n && wr_n) |=> exp_en_n_out && exp_rd_n_out && exp_wr_n_out)
    else $error("expansion strobes active without host strobe");
  chk_reg_private: assert property (
    (addr_hi == 8'hff && busy) |=> exp_en_n_out && sram_ce_n_out)
    else $error("register page routed outward");
  chk_sram_window: assert property (
    (in_sram && busy) |=> !sram_ce_n_out && exp_en_n_out)
    else $error("sram window not selected");
  // ****************************************
  // buffered reset
  // ****************************************
  chk_rst_low: assert property (disable iff (1'b0)
    sys_rst_in ##1 sys_rst_in |=> !buffered_reset_out_n)
    else $error("buffered reset high during reset");
  chk_rst_high: assert property (
    !sys_rst_in |=> buffered_reset_out_n)
    else $error("buffered reset low after reset");
  // main scenarios reached
  cov_exp_wr: cover property (!exp_en_n_out && !exp_wr_n_out);
  cov_exp_rd: cover property (!exp_en_n_out && !exp_rd_n_out);
  cov_sram: cover property (!sram_ce_n_out);
endmodule // xb_props
`default_nettype wire

/* test_banked_sram_and_expansion_decoder.sv */
// self-checking bench: host controller and decoder joined over the host bus
`default_nettype none
module test_banked_sram_and_expansion_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [4:0]  av_a = 5'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [18:0] sram_addr;
  logic        sram_ce_n, sram_oe_n, sram_we_n, sram_doe, exp_doe;
  logic [7:0]  sram_wd, exp_wd, sram_din;
  logic        exp_en_n, exp_rd_n, exp_wr_n, rst_out_n;
  logic [15:0] exp_addr, cap_ea;
  logic [7:0]  exp_din = 8'h00;
  logic [7:0]  cap_wd, cap_swd;
  logic [18:0] cap_sa;
  logic        seen_en, seen_sram;
  logic [31:0] rd_val;
  int          err_total = 0;
  int          comparisons = 0;
  logic [7:0]  bk [3] = '{8'h09, 8'hfa, 8'h0f};
  logic [15:0] sa [3] = '{16'h2200, 16'ha1ff, 16'h5a5a};
  logic [15:0] ea [3] = '{16'ha200, 16'hfeff, 16'hc3a5};
  // 100 mhz clock
  always #5 clk_in = ~clk_in;
  // sram returns the inverted low address so a wrong offset shows in the data
  assign sram_din = ~sram_addr[7:0];
  xbus_if i_xbus_if ();
  exp_host i_exp_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(av_a),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .bus(i_xbus_if));
  exp_decoder i_exp_decoder (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(i_xbus_if),
    .sram_addr_out(sram_addr), .sram_ce_n_out(sram_ce_n), .sram_oe_n_out(sram_oe_n),
    .sram_we_n_out(sram_we_n), .sram_data_out(sram_wd), .sram_data_oe_out(sram_doe),
    .sram_data_in(sram_din), .exp_en_n_out(exp_en_n), .exp_rd_n_out(exp_rd_n),
    .exp_wr_n_out(exp_wr_n), .exp_addr_out(exp_addr), .exp_data_out(exp_wd),
    .exp_data_oe_out(exp_doe), .exp_data_in(exp_din), .buffered_reset_out_n(rst_out_n));
  xb_props i_xb_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ad_h2d(i_xbus_if.ad_h2d), .ad_d2h(i_xbus_if.ad_d2h), .ad_d_oe(i_xbus_if.ad_d_oe),
    .addr_hi(i_xbus_if.addr_hi), .rd_n(i_xbus_if.rd_n), .wr_n(i_xbus_if.wr_n),
    .sram_ce_n_out(sram_ce_n), .exp_en_n_out(exp_en_n), .exp_rd_n_out(exp_rd_n),
    .exp_wr_n_out(exp_wr_n), .exp_addr_out(exp_addr), .exp_data_out(exp_wd),
    .exp_data_in(exp_din), .buffered_reset_out_n(rst_out_n));
  // capture what the outer side saw; strobes count only while enable is low
  always @(posedge clk_in) begin
    if (exp_en_n === 1'b0) begin
      seen_en = 1'b1;
      cap_ea = exp_addr;
      if (exp_wr_n === 1'b0 && exp_doe === 1'b1)
        cap_wd = exp_wd;
    end
    if (sram_ce_n === 1'b0) begin
      seen_sram = 1'b1;
      if (sram_oe_n === 1'b0)
        cap_sa = sram_addr;
      if (sram_we_n === 1'b0 && sram_doe === 1'b1)
        cap_swd = sram_wd;
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // avalon access: hold the request until waitrequest is sampled low
  // only the watchdog ends a wait that never gets an answer
  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    av_a <= a;
    av_wd <= d;
    av_rd <= rd;
    av_wr <= !rd;
    do begin
      @(posedge clk_in);
    end while (av_wait !== 1'b0);
    rd_val = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  // one host bus cycle, polled to done; read data left in rd_val
  task automatic op(input logic rd, input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] ws);
    seen_en = 1'b0;
    seen_sram = 1'b0;
    av(0, 5'h00, {16'h0, a});
    av(0, 5'h04, {24'h0, d});
    av(0, 5'h08, {26'h0, rd, !rd, ws, 2'b01});
    do begin
      av(1, 5'h0c, 32'h0);
    end while (rd_val[1] !== 1'b1);
    av(1, 5'h10, 32'h0);
  endtask
  task automatic stop_test();
    $display("mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end
    else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // a full run needs several hundred cycles
  initial begin
    #200_000;
    err_total++;
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [15:0] t;
    repeat (9) @(posedge clk_in);
    chk({31'h0, rst_out_n}, 32'h0);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({31'h0, rst_out_n}, 32'h1);
    av(0, 5'h08, 32'h1);
    av(1, 5'h14, 32'h0);
    chk(rd_val, 32'h0);
    op(1, 16'hff01, 8'h00, 2'h0);
    chk(rd_val, 32'h0);
    // bank select, upper bits dropped, then the window at that bank
    for (int i = 0; i < 3; i++) begin
      t = sa[i] - 16'h2200;
      op(0, 16'hff01, bk[i], 2'h0);
      op(1, 16'hff01, 8'h00, 2'h0);
      chk(rd_val, {28'h0, bk[i][3:0]});
      op(1, sa[i], 8'h00, 2'h0);
      chk({13'h0, cap_sa}, {13'h0, bk[i][3:0], t[14:0]});
      chk(rd_val, {24'h0, ~t[7:0]});
      chk({30'h0, seen_en, seen_sram}, 32'h1);
      op(0, sa[i], sa[i][7:0] ^ 8'h3c, 2'h0);
      chk({24'h0, cap_swd}, {24'h0, sa[i][7:0] ^ 8'h3c});
    end
    // expansion edges and middle, with host wait states 0, 3 and 2
    for (int i = 0; i < 3; i++) begin
      op(0, ea[i], ea[i][7:0] ^ 8'h5a, 2'(i * 3));
      chk({16'h0, cap_ea}, {16'h0, ea[i]});
      chk({24'h0, cap_wd}, {24'h0, ea[i][7:0] ^ 8'h5a});
      chk({30'h0, seen_en, seen_sram}, 32'h2);
      exp_din <= ~ea[i][15:8];
      op(1, ea[i], 8'h00, 2'(i * 3));
      chk(rd_val, {24'h0, ~ea[i][15:8]});
      exp_din <= ea[i][15:8];
    end
    // register page stays inside
    op(1, 16'hff00, 8'h00, 2'h0);
    chk(rd_val, 32'h0);
    chk({30'h0, seen_en, seen_sram}, 32'h0);
    // mid-run reset: bank is fifteen now and must fall back to zero
    sys_rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk({31'h0, rst_out_n}, 32'h0);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({31'h0, rst_out_n}, 32'h1);
    av(0, 5'h08, 32'h1);
    op(1, 16'hff01, 8'h00, 2'h0);
    chk(rd_val, 32'h0);
    stop_test();
  end
endmodule // test_banked_sram_and_expansion_decoder
`default_nettype wire
